//--- atrap_pkg.sv
// Constants shared by the instruction-fetch address trap block.
// Assumes an 8-bit register port and a 16-bit fetch address bus.
package atrap_pkg;

  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] CTRL_ONE_ADDR   = 8'h34;
  localparam logic [7:0] CODE_ADDR       = 8'h35;
  localparam logic [7:0] IRQ_STATUS_ADDR = 8'h36;
  localparam logic [7:0] IRQ_MASK_ADDR   = 8'h37;
  localparam logic [7:0] STATE_ADDR      = 8'h38;

  // ---------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------
  localparam int         RAM_TRAP_EN_BIT = 5;
  localparam int         ACTION_SEL_BIT  = 4;
  localparam logic       RAM_TRAP_EN_RST = 1'b1;
  localparam logic       ACTION_SEL_RST  = 1'b1;
  localparam logic [3:0] MASK_RST        = 4'h0;

  // Status / mask layout
  localparam int         STATUS_W        = 4;
  localparam int         ST_TRAP_IRQ     = 0;
  localparam int         ST_HIT_RAM      = 1;
  localparam int         ST_HIT_SFR      = 2;
  localparam int         ST_HIT_DBG      = 3;

  // State register layout
  localparam int         SR_RAM_EFF      = 0;
  localparam int         SR_RAM_PEND     = 1;
  localparam int         SR_ACTION       = 2;
  localparam int         SR_NMI_REQ      = 3;
  localparam int         SR_WAS_TRAP_RST = 4;

  // ---------------------------------------------------------------
  // Control codes
  // ---------------------------------------------------------------
  localparam logic [7:0] CODE_APPLY_AREA = 8'hd2;
  localparam logic [7:0] CODE_WDT_CLEAR  = 8'h4e;

  // ---------------------------------------------------------------
  // Timing: trap reset length, at most 24 high-frequency periods
  // ---------------------------------------------------------------
  localparam int FC_RESET_PERIODS = 24;
  localparam int FC_PERIOD_PS     = 10000;
  localparam int CORE_PERIOD_PS   = 10000;
  localparam int RESET_CYCLES_RAW =
    (FC_RESET_PERIODS * FC_PERIOD_PS) / CORE_PERIOD_PS;
  localparam int RESET_CYCLES     =
    (RESET_CYCLES_RAW < 1) ? 1 : RESET_CYCLES_RAW;

endpackage : atrap_pkg

//--- trap_area_if.sv
// Carries fetch addresses to the area classifier and hits back.
// Assumes both ends run on core_clk.
`timescale 1ns/1ps
interface trap_area_if #(parameter int AW = 16);
  logic          fetch_en;
  logic [AW-1:0] fetch_addr;
  logic          ram_trap_en;
  logic          hit_ram;
  logic          hit_sfr;
  logic          hit_dbg;

  modport ctrl (output fetch_en, output fetch_addr, output ram_trap_en,
                input hit_ram, input hit_sfr, input hit_dbg);
  modport area (input fetch_en, input fetch_addr, input ram_trap_en,
                output hit_ram, output hit_sfr, output hit_dbg);
endinterface : trap_area_if

//--- trap_area_classifier.sv
// Classifies instruction-fetch addresses into trapped areas.
// Assumes the caller qualifies fetch_en with instruction fetches only.
`timescale 1ns/1ps
module trap_area_classifier
  import atrap_pkg::*;
#(
  parameter int          AW       = 16,
  parameter logic [15:0] SFR_LO   = 16'h0000,
  parameter logic [15:0] SFR_HI   = 16'h003f,
  parameter logic [15:0] RAM_LO   = 16'h0040,
  parameter logic [15:0] RAM_HI   = 16'h023f,
  parameter logic [15:0] DBG_LO   = 16'h0f80,
  parameter logic [15:0] DBG_HI   = 16'h0fff
) (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic rst,
  // Fetch side
  trap_area_if.area tif
);

  typedef struct packed {
    logic hit_ram;
    logic hit_sfr;
    logic hit_dbg;
  } area_s;

  area_s st_r;
  area_s st_nxt;

  // Range test used for each area
  function automatic logic in_range(input logic [AW-1:0] a,
                                    input logic [15:0] lo,
                                    input logic [15:0] hi);
    in_range = (a >= lo[AW-1:0]) && (a <= hi[AW-1:0]);
  endfunction : in_range

  // ---------------------------------------------------------------
  // Hit decode, registered one cycle
  // ---------------------------------------------------------------
  always_comb begin
    st_nxt.hit_ram = tif.fetch_en && tif.ram_trap_en &&
                     in_range(tif.fetch_addr, RAM_LO, RAM_HI);
    // Always trapped, whatever the RAM setting
    st_nxt.hit_sfr = tif.fetch_en &&
                     in_range(tif.fetch_addr, SFR_LO, SFR_HI);
    st_nxt.hit_dbg = tif.fetch_en &&
                     in_range(tif.fetch_addr, DBG_LO, DBG_HI);
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign tif.hit_ram = st_r.hit_ram;
  assign tif.hit_sfr = st_r.hit_sfr;
  assign tif.hit_dbg = st_r.hit_dbg;

endmodule : trap_area_classifier

//--- trap_reset_pulse.sv
// Times the reset pulse that a trap drives onto the reset pin.
// Assumes start is a one-cycle pulse on core_clk.
`timescale 1ns/1ps
module trap_reset_pulse
  import atrap_pkg::*;
#(
  parameter int CYCLES = RESET_CYCLES
) (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic rst,
  // Control
  input  wire logic start,
  output logic      active,
  output logic      done
);

  localparam int CW = $clog2(CYCLES + 1);

  typedef struct packed {
    logic          active;
    logic          done;
    logic [CW-1:0] cnt;
  } pulse_s;

  pulse_s st_r;
  pulse_s st_nxt;

  // ---------------------------------------------------------------
  // Count down; a new start while busy is ignored
  // ---------------------------------------------------------------
  always_comb begin
    st_nxt      = st_r;
    st_nxt.done = 1'b0;
    if (!st_r.active && start) begin
      st_nxt.active = 1'b1;
      st_nxt.cnt    = CW'(CYCLES - 1);
    end else if (st_r.active) begin
      if (st_r.cnt == '0) begin
        st_nxt.active = 1'b0;
        st_nxt.done   = 1'b1;
      end else begin
        st_nxt.cnt = st_r.cnt - CW'(1);
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign active = st_r.active;
  assign done   = st_r.done;

endmodule : trap_reset_pulse

//--- instruction_fetch_address_trap.sv
// Instruction-fetch address trap: register port, trap decision,
// non-maskable request and reset pin drive.
// Assumes the CPU marks instruction fetches and acknowledges the NMI.
`timescale 1ns/1ps

module instruction_fetch_address_trap
  import atrap_pkg::*;
#(
  parameter int          AW           = 16,
  parameter int          RESET_CYC    = RESET_CYCLES,
  parameter logic [15:0] SFR_LO       = 16'h0000,
  parameter logic [15:0] SFR_HI       = 16'h003f,
  parameter logic [15:0] RAM_LO       = 16'h0040,
  parameter logic [15:0] RAM_HI       = 16'h023f,
  parameter logic [15:0] DBG_LO       = 16'h0f80,
  parameter logic [15:0] DBG_HI       = 16'h0fff
) (
  // Clock and reset
  input  wire logic          core_clk,
  input  wire logic          rst,
  // Register port
  input  wire logic [7:0]    reg_addr,
  input  wire logic [7:0]    reg_wdata,
  input  wire logic          reg_wr,
  input  wire logic          reg_rd,
  output logic      [7:0]    reg_rdata,
  // CPU fetch monitor
  input  wire logic          fetch_valid,
  input  wire logic          fetch_is_instr,
  input  wire logic [AW-1:0] fetch_addr,
  // CPU non-maskable trap request
  output logic               address_trap_irq,
  input  wire logic          trap_irq_ack,
  // Clock mode
  input  wire logic          low_speed_mode_one,
  output logic               hf_osc_restart,
  // Reset pin and internal reset
  output logic               rst_pin_out_n,
  output logic               rst_pin_oe,
  output logic               internal_rst_req,
  // Watchdog side
  output logic               wdt_counter_clear,
  // Interrupt to the system controller
  output logic               irq
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic                ram_en_pend;
    logic                ram_en_eff;
    logic                action_sel;
    logic [STATUS_W-1:0] status;
    logic [STATUS_W-1:0] mask;
    logic                nmi_req;
    logic                was_trap_rst;
    logic                osc_restart;
    logic                wdt_clr;
    logic [7:0]          rdata;
  } ctl_s;

  ctl_s st_r;
  ctl_s st_nxt;

  // Reset values shared by power-up and trap reset
  localparam ctl_s CTL_RST = '{
    ram_en_pend:  RAM_TRAP_EN_RST,
    ram_en_eff:   RAM_TRAP_EN_RST,
    action_sel:   ACTION_SEL_RST,
    status:       '0,
    mask:         MASK_RST,
    nmi_req:      1'b0,
    was_trap_rst: 1'b0,
    osc_restart:  1'b0,
    wdt_clr:      1'b0,
    rdata:        8'h00
  };

  // ---------------------------------------------------------------
  // Sub-blocks
  // ---------------------------------------------------------------
  trap_area_if #(.AW(AW)) tif ();

  logic pulse_start;
  logic pulse_active;
  logic pulse_done;

  trap_area_classifier #(
    .AW     (AW),
    .SFR_LO (SFR_LO),
    .SFR_HI (SFR_HI),
    .RAM_LO (RAM_LO),
    .RAM_HI (RAM_HI),
    .DBG_LO (DBG_LO),
    .DBG_HI (DBG_HI)
  ) u_area (
    .core_clk (core_clk),
    .rst      (rst),
    .tif      (tif)
  );

  trap_reset_pulse #(
    .CYCLES (RESET_CYC)
  ) u_pulse (
    .core_clk (core_clk),
    .rst      (rst),
    .start    (pulse_start),
    .active   (pulse_active),
    .done     (pulse_done)
  );

  // ---------------------------------------------------------------
  // Fetch qualification
  // ---------------------------------------------------------------
  // Data accesses never reach the compare; fetches during the
  // trap reset are ignored since the CPU is held then.
  assign tif.fetch_en    = fetch_valid && fetch_is_instr &&
                           !pulse_active;
  assign tif.fetch_addr  = fetch_addr;
  assign tif.ram_trap_en = st_r.ram_en_eff;

  // ---------------------------------------------------------------
  // Decode helpers
  // ---------------------------------------------------------------
  logic trap_hit;
  logic wr_ctrl;
  logic wr_code;
  logic wr_mask;
  logic rd_status;

  // Trap and watchdog functions share the code offset; the control offset serves the trap only
  assign wr_ctrl   = reg_wr && (reg_addr == CTRL_ONE_ADDR);
  assign wr_code   = reg_wr && (reg_addr == CODE_ADDR);
  assign wr_mask   = reg_wr && (reg_addr == IRQ_MASK_ADDR);
  assign rd_status = reg_rd && (reg_addr == IRQ_STATUS_ADDR);
  assign trap_hit  = tif.hit_ram || tif.hit_sfr || tif.hit_dbg;

  // A reset request starts the pin pulse; interrupts do not
  assign pulse_start = trap_hit && st_r.action_sel;

  // Read mux; write-only and unmapped offsets read zero
  function automatic logic [7:0] read_mux(input logic [7:0] a,
                                          input ctl_s s);
    read_mux = 8'h00;
    unique case (a)
      IRQ_STATUS_ADDR: read_mux = 8'(s.status);
      IRQ_MASK_ADDR:   read_mux = 8'(s.mask);
      STATE_ADDR: begin
        read_mux[SR_RAM_EFF]      = s.ram_en_eff;
        read_mux[SR_RAM_PEND]     = s.ram_en_pend;
        read_mux[SR_ACTION]       = s.action_sel;
        read_mux[SR_NMI_REQ]      = s.nmi_req;
        read_mux[SR_WAS_TRAP_RST] = s.was_trap_rst;
      end
      default:         read_mux = 8'h00;
    endcase
  endfunction : read_mux

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    st_nxt         = st_r;
    st_nxt.wdt_clr = 1'b0;
    st_nxt.rdata   = 8'h00;

    // Control register: pending RAM enable and action select
    if (wr_ctrl) begin
      st_nxt.ram_en_pend = reg_wdata[RAM_TRAP_EN_BIT];
      st_nxt.action_sel  = reg_wdata[ACTION_SEL_BIT];
    end

    // Code register; any other value is dropped
    if (wr_code) begin
      if (reg_wdata == CODE_APPLY_AREA) begin
        st_nxt.ram_en_eff = wr_ctrl ? reg_wdata[RAM_TRAP_EN_BIT]
                                    : st_r.ram_en_pend;
      end else if (reg_wdata == CODE_WDT_CLEAR) begin
        st_nxt.wdt_clr = 1'b1;
      end
    end

    if (wr_mask) begin
      st_nxt.mask = reg_wdata[STATUS_W-1:0];
    end

    // Status: read clears, a same-cycle event still sets
    if (rd_status) begin
      st_nxt.status = '0;
    end
    st_nxt.status[ST_HIT_RAM] = st_nxt.status[ST_HIT_RAM] |
                                tif.hit_ram;
    st_nxt.status[ST_HIT_SFR] = st_nxt.status[ST_HIT_SFR] |
                                tif.hit_sfr;
    st_nxt.status[ST_HIT_DBG] = st_nxt.status[ST_HIT_DBG] |
                                tif.hit_dbg;

    // Interrupt action. The request is raised even while another
    // trap is in service, so the CPU nests at once; the master
    // flag is not looked at.
    if (trap_irq_ack) begin
      st_nxt.nmi_req = 1'b0;
    end
    if (trap_hit && !st_r.action_sel) begin
      st_nxt.nmi_req             = 1'b1;
      st_nxt.status[ST_TRAP_IRQ] = 1'b1;
    end

    // Oscillator restart only matters in the slow mode
    if (pulse_start && low_speed_mode_one) begin
      st_nxt.osc_restart = 1'b1;
    end

    // Read data for the cycle after the strobe
    if (reg_rd) begin
      st_nxt.rdata = read_mux(reg_addr, st_r);
    end

    // Trap reset: block back to reset values except the oscillator restart. The cause flag
    // survives so software can tell why it restarted.
    if (pulse_active) begin
      st_nxt              = CTL_RST;
      st_nxt.was_trap_rst = 1'b1;
      st_nxt.osc_restart  = st_r.osc_restart;
    end
    if (pulse_done) begin
      st_nxt.osc_restart = 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_r <= CTL_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign reg_rdata         = st_r.rdata;
  assign address_trap_irq  = st_r.nmi_req;
  assign wdt_counter_clear = st_r.wdt_clr;
  assign hf_osc_restart    = st_r.osc_restart;

  // Open-drain reset pin: pull low for the timed pulse only
  assign rst_pin_oe        = pulse_active;
  assign rst_pin_out_n     = 1'b0;
  assign internal_rst_req  = pulse_active;

  // Level interrupt while any unmasked status bit stands
  assign irq = |(st_r.status & st_r.mask);

endmodule : instruction_fetch_address_trap

//--- atrap_sva.sv
// Checker for the fetch address trap block, port relations only.
// Assumes it is bound to the block and sees only its top ports.
`timescale 1ns/1ps
module atrap_sva
  import atrap_pkg::*;
#(
  parameter int          RESET_CYC = RESET_CYCLES,
  parameter logic [15:0] SFR_HI    = 16'h003f,
  parameter logic [15:0] DBG_LO    = 16'h0f80,
  parameter logic [15:0] DBG_HI    = 16'h0fff
) (
  // Clock and reset
  input wire logic        core_clk,
  input wire logic        rst,
  // Register port
  input wire logic [7:0]  reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_rdata,
  // Fetch monitor and outputs
  input wire logic        fetch_valid,
  input wire logic        fetch_is_instr,
  input wire logic [15:0] fetch_addr,
  input wire logic        address_trap_irq,
  input wire logic        low_speed_mode_one,
  input wire logic        hf_osc_restart,
  input wire logic        rst_pin_out_n,
  input wire logic        rst_pin_oe,
  input wire logic        internal_rst_req,
  input wire logic        wdt_counter_clear
);
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  logic [7:0] oe_cnt_r;
  logic       area_hit;
  logic       wr_clear;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // Area fetches that must trap whatever the RAM setting
  assign area_hit = fetch_valid && fetch_is_instr && (fetch_addr <= SFR_HI
                    || (fetch_addr >= DBG_LO && fetch_addr <= DBG_HI));
  assign wr_clear = reg_wr && reg_addr == CODE_ADDR
                    && reg_wdata == CODE_WDT_CLEAR;
  // Pulse length counter; a plain repetition cannot hold 24
  always_ff @(posedge core_clk) begin
    if (rst || !rst_pin_oe) oe_cnt_r <= 8'h00;
    else oe_cnt_r <= oe_cnt_r + 8'h01;
  end
  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  a_pin_drive: assert property (
    rst_pin_oe == internal_rst_req && !rst_pin_out_n)
    else $error("reset pin and internal reset disagree");
  a_area_trap: assert property (
    area_hit && !rst_pin_oe |-> ##2 (address_trap_irq || rst_pin_oe))
    else $error("no trap after area fetch");
  a_nmi_cause: assert property (
    $rose(address_trap_irq) |-> $past(fetch_valid && fetch_is_instr, 2))
    else $error("trap request without instruction fetch");
  a_pulse_cause: assert property (
    $rose(rst_pin_oe) |-> $past(fetch_valid && fetch_is_instr, 2))
    else $error("reset pulse without instruction fetch");
  a_pulse_max: assert property (
    rst_pin_oe |-> oe_cnt_r < RESET_CYC)
    else $error("reset pulse too long");
  a_pulse_len: assert property (
    $fell(rst_pin_oe) |-> oe_cnt_r == RESET_CYC)
    else $error("reset pulse length wrong");
  a_osc_start: assert property (
    $rose(rst_pin_oe) && low_speed_mode_one |-> ##[0:1] hf_osc_restart)
    else $error("oscillator restart missing");
  a_osc_bound: assert property (
    hf_osc_restart |-> rst_pin_oe || $past(rst_pin_oe))
    else $error("oscillator restart outside pulse");
  a_clear_pulse: assert property (
    (wr_clear && !rst_pin_oe) ##1 !rst_pin_oe |-> wdt_counter_clear)
    else $error("counter clear missing");
  a_clear_cause: assert property (
    wdt_counter_clear |-> $past(wr_clear))
    else $error("counter clear without code");
  a_rdata_quiet: assert property (
    $past(!reg_rd || reg_addr == CTRL_ONE_ADDR || reg_addr == CODE_ADDR)
    |-> reg_rdata == 8'h00)
    else $error("read data outside read slot");
endmodule : atrap_sva

bind instruction_fetch_address_trap atrap_sva #(
  .RESET_CYC(RESET_CYC), .SFR_HI(SFR_HI), .DBG_LO(DBG_LO), .DBG_HI(DBG_HI)
) u_atrap_sva (
  .core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .fetch_valid(fetch_valid),
  .fetch_is_instr(fetch_is_instr), .fetch_addr(fetch_addr),
  .address_trap_irq(address_trap_irq),
  .low_speed_mode_one(low_speed_mode_one),
  .hf_osc_restart(hf_osc_restart), .rst_pin_out_n(rst_pin_out_n),
  .rst_pin_oe(rst_pin_oe), .internal_rst_req(internal_rst_req),
  .wdt_counter_clear(wdt_counter_clear)
);

//--- cpu_core_model.sv
// Model of the CPU core on the fetch side of the trap block.
// Assumes the bench starts accesses through the fetch task.
`timescale 1ns/1ps
module cpu_core_model (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst,
  // Trap request and its acknowledge
  input  wire logic       address_trap_irq,
  input  wire logic [7:0] ack_dly,
  output logic            trap_irq_ack,
  // Bus accesses
  output logic            fetch_valid,
  output logic            fetch_is_instr,
  output logic [15:0]     fetch_addr
);
  logic [7:0] wait_cnt;
  initial begin
    fetch_valid = 1'b0;
    fetch_is_instr = 1'b0;
    fetch_addr = 16'h5a5a;
    trap_irq_ack = 1'b0;
  end
  // One access; address turns to junk after it, never left stale
  task automatic fetch(input logic [15:0] a, input logic instr);
    @(posedge core_clk);
    fetch_valid <= 1'b1;
    fetch_is_instr <= instr;
    fetch_addr <= a;
    @(posedge core_clk);
    fetch_valid <= 1'b0;
    fetch_is_instr <= ~instr;
    fetch_addr <= ~a;
  endtask : fetch
  // Each trap is taken and returned from; zero delay stalls forever
  always @(posedge core_clk) begin
    trap_irq_ack <= 1'b0;
    if (rst || !address_trap_irq || ack_dly == 8'h00) begin
      wait_cnt <= 8'h00;
    end else if (wait_cnt == ack_dly) begin
      trap_irq_ack <= 1'b1;
      wait_cnt <= 8'h00;
    end else begin
      wait_cnt <= wait_cnt + 8'h01;
    end
  end
endmodule : cpu_core_model

//--- instruction_fetch_address_trap_bench.sv
// Bench for the fetch address trap: register calls and fetches.
// Assumes a shortened reset pulse of RC cycles.
`timescale 1ns/1ps
module instruction_fetch_address_trap_bench
  import atrap_pkg::*;
;
  localparam int RC = 3;
  logic        core_clk, rst, reg_wr, reg_rd, low_speed_mode_one;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, ack_dly;
  logic        fetch_valid, fetch_is_instr, trap_irq_ack;
  logic [15:0] fetch_addr;
  logic        address_trap_irq, hf_osc_restart, rst_pin_out_n;
  logic        rst_pin_oe, internal_rst_req, wdt_counter_clear, irq;
  int          err_count, num_checks, n, hf_n;

  instruction_fetch_address_trap #(.RESET_CYC(RC))
    u_instruction_fetch_address_trap (
    .core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .fetch_valid(fetch_valid),
    .fetch_is_instr(fetch_is_instr), .fetch_addr(fetch_addr),
    .address_trap_irq(address_trap_irq), .trap_irq_ack(trap_irq_ack),
    .low_speed_mode_one(low_speed_mode_one),
    .hf_osc_restart(hf_osc_restart), .rst_pin_out_n(rst_pin_out_n),
    .rst_pin_oe(rst_pin_oe), .internal_rst_req(internal_rst_req),
    .wdt_counter_clear(wdt_counter_clear), .irq(irq));
  cpu_core_model u_cpu_core_model (
    .core_clk(core_clk), .rst(rst), .address_trap_irq(address_trap_irq),
    .ack_dly(ack_dly), .trap_irq_ack(trap_irq_ack),
    .fetch_valid(fetch_valid), .fetch_is_instr(fetch_is_instr),
    .fetch_addr(fetch_addr));

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr
  // Read data stand only in the slot after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] exp,
                    input string what);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    chk(what, exp, reg_rdata);
  endtask : rd
  task automatic settle(input int k);
    repeat (k) @(posedge core_clk);
    #1;
  endtask : settle
  task automatic final_report;
    if (err_count == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : final_report

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // Watchdog: the tests need about a hundred cycles
  initial begin
    #200000;
    err_count++;
    final_report;
  end

  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  initial begin
    {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
    {low_speed_mode_one, ack_dly, err_count, num_checks} = '0;
    rst = 1'b1;
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    // Reset values and refused reads
    rd(STATE_ADDR, 8'h07, "reset state");
    rd(IRQ_MASK_ADDR, 8'h00, "reset mask");
    rd(CTRL_ONE_ADDR, 8'h00, "control read");
    rd(8'h3f, 8'h00, "unmapped read");
    // Data access to the register area never traps
    u_cpu_core_model.fetch(16'h0010, 1'b0);
    settle(3);
    chk("data access pin", 8'h00, {7'h0, rst_pin_oe});
    // RAM enable cleared but not yet applied: still traps
    wr(IRQ_MASK_ADDR, 8'h01);
    wr(CTRL_ONE_ADDR, 8'h00);
    rd(STATE_ADDR, 8'h01, "pending state");
    u_cpu_core_model.fetch(16'h0100, 1'b1);
    settle(2);
    chk("ram trap request", 8'h01, {7'h0, address_trap_irq});
    chk("ram irq", 8'h01, {7'h0, irq});
    rd(IRQ_STATUS_ADDR, 8'h03, "ram status");
    settle(1);
    chk("irq after read", 8'h00, {7'h0, irq});
    wr(CODE_ADDR, CODE_APPLY_AREA);
    rd(STATE_ADDR, 8'h08, "applied state");
    u_cpu_core_model.fetch(16'h0100, 1'b1);
    settle(2);
    rd(IRQ_STATUS_ADDR, 8'h00, "ram off status");
    // Register and debug areas trap; mask gates the level output
    wr(IRQ_MASK_ADDR, 8'h00);
    u_cpu_core_model.fetch(16'h0020, 1'b1);
    u_cpu_core_model.fetch(16'h0f90, 1'b1);
    settle(2);
    chk("masked irq", 8'h00, {7'h0, irq});
    wr(IRQ_MASK_ADDR, 8'h0f);
    settle(1);
    chk("unmasked irq", 8'h01, {7'h0, irq});
    rd(IRQ_STATUS_ADDR, 8'h0d, "area status");
    // Trap taken, then a new one while still in service
    ack_dly <= 8'h02;
    n = 0;
    while (address_trap_irq !== 1'b0 && n < 20) begin
      settle(1);
      n++;
    end
    chk("request taken", 8'h00, {7'h0, address_trap_irq});
    u_cpu_core_model.fetch(16'h0030, 1'b1);
    settle(2);
    chk("nested request", 8'h01, {7'h0, address_trap_irq});
    // Codes: clear, invalid, apply
    wr(CODE_ADDR, CODE_WDT_CLEAR);
    #1;
    chk("counter clear", 8'h01, {7'h0, wdt_counter_clear});
    wr(CTRL_ONE_ADDR, 8'h20);
    wr(CODE_ADDR, 8'h55);
    rd(STATE_ADDR, 8'h02, "invalid code");
    wr(CODE_ADDR, CODE_APPLY_AREA);
    rd(STATE_ADDR, 8'h03, "reapplied state");
    // Reset action in slow mode, debug area upper bound
    wr(CTRL_ONE_ADDR, 8'h30);
    @(posedge core_clk);
    low_speed_mode_one <= 1'b1;
    u_cpu_core_model.fetch(16'h0fff, 1'b1);
    {n, hf_n} = '0;
    while (rst_pin_oe !== 1'b1 && n < 10) begin
      settle(1);
      n++;
    end
    n = 0;
    while (rst_pin_oe === 1'b1 && n < 100) begin
      if (hf_osc_restart === 1'b1) hf_n++;
      settle(1);
      n++;
    end
    chk("pulse length", 8'(RC), n[7:0]);
    chk("oscillator restart", 8'h01, {7'h0, hf_n > 0});
    rd(STATE_ADDR, 8'h17, "state after pulse");
    final_report;
  end
endmodule : instruction_fetch_address_trap_bench
